// ===== hw/fdms_pkg.sv
// constants, field layout and state codes for the dma channel mode block
// assumes a single 10 MHz clock and the documented register offsets
//
// What this block does
// - The width field uses pattern 11 for 32-bit accesses and 00 for 8-bit, and a demand-mode access is a full word.
// - Byte packing at 8-bit width applies only without demand mode and is not used while demand mode is on.
// - The ready handshake is honoured when enabled, and the burst-terminate input only acts if its bit is set.
// - With bursting enabled the local accesses follow back to back without idle cycles.
// - With chaining on, each segment's source, destination and count are fetched from host-side descriptors.
// - With the done interrupt enabled the channel signals an interrupt when its transfer completes.
// - With no-increment addressing every local access goes to the same FIFO address.
// - With demand mode on, accesses run only while the FIFO request line is asserted.
// - The interrupt select bit routes the done interrupt to the host or to the local side.
// - The write-and-invalidate bit is stored as software chose and passed on with the transfer.
// - Two independent channels 0 and 1 each have their own mode register.
// - Transfers target the FIFO locations only, in demand or in non-demand mode.
package fdms_pkg;
  typedef logic [31:0] fdms_word_t;
  typedef logic [7:0] fdms_addr_t;

  localparam fdms_addr_t OFF_MODE0 = 8'h80;
  localparam fdms_addr_t OFF_MODE1 = 8'h94;
  localparam fdms_word_t MODE_MASK = 32'h0003_ffff;
  localparam fdms_word_t MODE_RST = 32'h0000_0000;

  localparam int unsigned F_WIDTH = 0;
  localparam int unsigned F_READY = 2;
  localparam int unsigned F_BTERM = 7;
  localparam int unsigned F_BURST = 8;
  localparam int unsigned F_CHAIN = 9;
  localparam int unsigned F_DONE_IE = 10;
  localparam int unsigned F_NOINC = 11;
  localparam int unsigned F_DEMAND = 12;
  localparam int unsigned F_WINV = 13;
  localparam int unsigned F_ISEL = 17;

  localparam logic [1:0] WIDTH_32 = 2'h3;
  localparam logic [1:0] WIDTH_8 = 2'h0;

  localparam fdms_word_t STEP_WORD = 32'h0000_0004;
  localparam fdms_word_t STEP_BYTE = 32'h0000_0001;
  localparam logic [1:0] DESC_LAST = 2'h3;
  localparam logic [1:0] LANE_LAST = 2'h3;

  localparam int unsigned FIFO_WIDTH = 32;
  localparam int unsigned FIFO_DEPTH = 16;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_DESC = 4'h2,
    ST_XFER = 4'h4,
    ST_DONE = 4'h8
  } fdms_state_t;
endpackage : fdms_pkg

// ===== hw/fdms_fifo.sv
// data fifo between the local fifo reads and the host stream
// assumes one clock; read data leave from a register
`timescale 1ns/1ps
module fdms_fifo #(
  parameter int unsigned W = 32,
  parameter int unsigned D = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // fill side
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  output logic almost_full,
  // drain side
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  localparam int unsigned AW = $clog2(D);
  localparam int unsigned CW = $clog2(D + 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(D);
  localparam logic [CW-1:0] CNT_ALMOST = CW'(D - 1);

  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_ptr_q, rd_ptr_q;
  logic [CW-1:0] cnt_q;
  logic out_valid_q;
  logic [W-1:0] out_data_q;

  wire push = in_valid && in_ready;
  wire pop = (cnt_q != '0) && (!out_valid_q || out_ready);
  assign in_ready = (cnt_q != CNT_FULL);
  assign almost_full = (cnt_q >= CNT_ALMOST);
  assign out_valid = out_valid_q;
  assign out_data = out_data_q;

  // memory itself carries no reset
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_q] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q <= '0;
      out_valid_q <= 1'b0;
      out_data_q <= '0;
    end else begin
      if (push) wr_ptr_q <= AW'(wr_ptr_q + 1'b1);
      if (pop) rd_ptr_q <= AW'(rd_ptr_q + 1'b1);
      cnt_q <= CW'(cnt_q + CW'(push) - CW'(pop));
      if (pop) out_data_q <= mem[rd_ptr_q];
      if (pop) out_valid_q <= 1'b1;
      else if (out_ready) out_valid_q <= 1'b0;
    end
  end
endmodule : fdms_fifo

// ===== hw/fdms_top.sv
// one dma engine serving two channels, one channel at a time, over one local fifo read path
// assumes local fifo logic and descriptor memory on the same clock
`timescale 1ns/1ps
module fdms_top #(
  parameter int unsigned FIFO_W = fdms_pkg::FIFO_WIDTH,
  parameter int unsigned FIFO_D = fdms_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // mode register port
  input wire fdms_pkg::fdms_addr_t REG_ADDR,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire fdms_pkg::fdms_word_t REG_WDATA,
  output fdms_pkg::fdms_word_t REG_RDATA,
  output logic REG_ACK,
  // channel control
  input wire logic [1:0] CH_START,
  input wire fdms_pkg::fdms_word_t CH_LOCAL_ADDR,
  input wire fdms_pkg::fdms_word_t CH_HOST_ADDR,
  input wire logic [15:0] CH_BYTES,
  input wire fdms_pkg::fdms_word_t CH_DESC_PTR,
  output logic [1:0] CH_BUSY,
  // descriptor reads
  output logic DESC_RD,
  output fdms_pkg::fdms_word_t DESC_ADDR,
  input wire logic DESC_ACK,
  input wire fdms_pkg::fdms_word_t DESC_DATA,
  // local fifo bus
  output fdms_pkg::fdms_word_t LB_ADDR,
  output logic LB_RD,
  output logic LB_LAST,
  input wire logic LB_READY,
  input wire logic LB_BTERM_N,
  input wire fdms_pkg::fdms_word_t LB_DATA,
  input wire logic DMA_REQUEST_LINE_N,
  // host stream
  output fdms_pkg::fdms_word_t HOST_ADDR,
  output logic HOST_VALID,
  output logic [FIFO_W-1:0] HOST_DATA,
  input wire logic HOST_READY,
  output logic HOST_WINV,
  // done interrupts
  output logic IRQ_HOST,
  output logic IRQ_LOCAL
);
  import fdms_pkg::*;

  function automatic logic hit(input fdms_addr_t a, input fdms_addr_t off);
    hit = (a == off);
  endfunction : hit

  // one access per fifo byte when packing, else one per word
  function automatic logic [15:0] acc_of(input logic [15:0] bytes,
                                         input logic pk);
    acc_of = pk ? bytes : 16'((17'(bytes) + 17'h00003) >> 2);
  endfunction : acc_of

  function automatic logic packs(input fdms_word_t m);
    packs = (m[F_WIDTH +: 2] == WIDTH_8) && !m[F_DEMAND];
  endfunction : packs

  fdms_word_t mode_q [2];
  fdms_state_t state_q, state_d;
  logic chan_q;
  logic lb_rd_q, lb_rd_d, lb_last_q;
  fdms_word_t lb_addr_q, lb_addr_d, host_addr_q, next_q;
  logic [15:0] acc_left_q, acc_left_d;
  logic [1:0] lane_q, desc_idx_q;
  fdms_word_t pack_q;
  logic desc_rd_q;
  fdms_word_t desc_addr_q;
  logic [1:0] busy_q;
  logic irq_host_q, irq_local_q, winv_q;
  fdms_word_t rdata_q;
  logic ack_q;
  logic req_s1_q, req_s2_q, req_s3_q, req_lvl_q;
  logic f_in_ready, f_almost;

  // active channel view of its mode
  wire fdms_word_t am = mode_q[chan_q];
  wire pack = packs(am);
  wire ready_en = |am[F_READY +: 2];
  wire burst_en = am[F_BURST];
  wire bterm_hit = am[F_BTERM] && !LB_BTERM_N;
  wire noinc = am[F_NOINC];
  wire demand = am[F_DEMAND];
  wire dem_ok = !demand || req_lvl_q;

  wire acc_done = lb_rd_q && (!ready_en || LB_READY);
  wire last_acc = (acc_left_q == 16'h0001);
  wire push = acc_done && (!pack || lane_q == LANE_LAST || last_acc);
  wire room = f_in_ready && !(push && f_almost);
  wire fdms_word_t lane_word = {24'h0, LB_DATA[7:0]} << {lane_q, 3'h0};
  wire fdms_word_t push_data = pack ? (pack_q | lane_word) : LB_DATA;
  wire fdms_word_t step = pack ? STEP_BYTE : STEP_WORD;

  wire start_any = (state_q == ST_IDLE) && (|CH_START);
  wire sel = !CH_START[0];
  wire fdms_word_t sel_mode = mode_q[sel];
  wire sel_chain = sel_mode[F_CHAIN];
  wire desc_end = desc_rd_q && DESC_ACK && (desc_idx_q == DESC_LAST);
  wire chain_more = am[F_CHAIN] && (next_q != '0);

  wire wr0 = REG_WR && hit(REG_ADDR, OFF_MODE0);
  wire wr1 = REG_WR && hit(REG_ADDR, OFF_MODE1);
  wire fdms_word_t rd_mux = hit(REG_ADDR, OFF_MODE0) ? mode_q[0] :
                            hit(REG_ADDR, OFF_MODE1) ? mode_q[1] : '0;

  // pin request: three stages, level follows once stages two and three agree
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      req_s3_q <= 1'b0;
      req_lvl_q <= 1'b0;
    end else begin
      req_s1_q <= !DMA_REQUEST_LINE_N;
      req_s2_q <= req_s1_q;
      req_s3_q <= req_s2_q;
      if (req_s2_q == req_s3_q) req_lvl_q <= req_s3_q;
    end
  end

  // mode registers, reserved bits never stored
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      mode_q[0] <= MODE_RST;
      mode_q[1] <= MODE_RST;
      rdata_q <= '0;
      ack_q <= 1'b0;
    end else begin
      if (wr0) mode_q[0] <= REG_WDATA & MODE_MASK;
      if (wr1) mode_q[1] <= REG_WDATA & MODE_MASK;
      if (REG_RD) rdata_q <= rd_mux;
      ack_q <= REG_WR || REG_RD;
    end
  end

  // sequencing of fetch, transfer and completion
  always_comb begin
    state_d = state_q;
    lb_rd_d = lb_rd_q;
    lb_addr_d = lb_addr_q;
    acc_left_d = acc_left_q;
    unique case (state_q)
      ST_IDLE: begin
        if (start_any) begin
          state_d = sel_chain ? ST_DESC : ST_XFER;
          lb_addr_d = CH_LOCAL_ADDR;
          acc_left_d = acc_of(CH_BYTES, packs(sel_mode));
        end
      end
      ST_DESC: begin
        if (desc_rd_q && DESC_ACK && desc_idx_q == 2'h0) begin
          lb_addr_d = DESC_DATA;
        end
        if (desc_rd_q && DESC_ACK && desc_idx_q == 2'h2) begin
          acc_left_d = acc_of(DESC_DATA[15:0], pack);
        end
        if (desc_end) state_d = ST_XFER;
      end
      ST_XFER: begin
        if (!lb_rd_q) begin
          lb_rd_d = room && dem_ok && (acc_left_q != '0);
          if (acc_left_q == '0) state_d = ST_DONE;
        end else if (acc_done) begin
          acc_left_d = 16'(acc_left_q - 16'h0001);
          lb_addr_d = noinc ? lb_addr_q : 32'(lb_addr_q + step);
          // back to back only while bursting
          lb_rd_d = burst_en && !bterm_hit && !last_acc && room &&
                    dem_ok;
        end
      end
      ST_DONE: begin
        state_d = chain_more ? ST_DESC : ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      state_q <= ST_IDLE;
      chan_q <= 1'b0;
      lb_rd_q <= 1'b0;
      lb_last_q <= 1'b0;
      lb_addr_q <= '0;
      acc_left_q <= '0;
    end else begin
      state_q <= state_d;
      if (start_any) chan_q <= sel;
      lb_rd_q <= lb_rd_d;
      lb_last_q <= lb_rd_d && (acc_left_d == 16'h0001);
      lb_addr_q <= lb_addr_d;
      acc_left_q <= acc_left_d;
    end
  end

  // byte packing lanes; a short final word is pushed as it stands
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      lane_q <= '0;
      pack_q <= '0;
    end else if (push || start_any || state_q == ST_DESC) begin
      lane_q <= '0;
      pack_q <= '0;
    end else if (acc_done && pack) begin
      lane_q <= 2'(lane_q + 2'h1);
      pack_q <= pack_q | lane_word;
    end
  end

  // descriptor walk: source, destination, count, next
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      desc_rd_q <= 1'b0;
      desc_addr_q <= '0;
      desc_idx_q <= '0;
      host_addr_q <= '0;
      next_q <= '0;
    end else if ((start_any && sel_chain) ||
                 (state_q == ST_DONE && chain_more)) begin
      desc_rd_q <= 1'b1;
      desc_addr_q <= start_any ? CH_DESC_PTR : next_q;
      desc_idx_q <= '0;
    end else if (start_any) begin
      host_addr_q <= CH_HOST_ADDR;
      next_q <= '0;
    end else if (desc_rd_q && DESC_ACK) begin
      desc_addr_q <= 32'(desc_addr_q + STEP_WORD);
      desc_idx_q <= 2'(desc_idx_q + 2'h1);
      if (desc_idx_q == 2'h1) host_addr_q <= DESC_DATA;
      if (desc_idx_q == DESC_LAST) next_q <= DESC_DATA;
      if (desc_idx_q == DESC_LAST) desc_rd_q <= 1'b0;
    end
  end

  // completion signalling and status
  wire done_now = (state_q == ST_DONE) && !chain_more;
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      irq_host_q <= 1'b0;
      irq_local_q <= 1'b0;
      busy_q <= '0;
      winv_q <= 1'b0;
    end else begin
      irq_host_q <= done_now && am[F_DONE_IE] && am[F_ISEL];
      irq_local_q <= done_now && am[F_DONE_IE] && !am[F_ISEL];
      busy_q[0] <= (state_d != ST_IDLE) && !(start_any ? sel : chan_q);
      busy_q[1] <= (state_d != ST_IDLE) && (start_any ? sel : chan_q);
      winv_q <= am[F_WINV];
    end
  end

  // host side back-pressure reaches the local reads through room
  fdms_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
    .clk(REF_CLK),
    .rst(RST),
    .in_valid(push),
    .in_data(FIFO_W'(push_data)),
    .in_ready(f_in_ready),
    .almost_full(f_almost),
    .out_valid(HOST_VALID),
    .out_data(HOST_DATA),
    .out_ready(HOST_READY)
  );

  assign REG_RDATA = rdata_q;
  assign REG_ACK = ack_q;
  assign CH_BUSY = busy_q;
  assign DESC_RD = desc_rd_q;
  assign DESC_ADDR = desc_addr_q;
  assign LB_ADDR = lb_addr_q;
  assign LB_RD = lb_rd_q;
  assign LB_LAST = lb_last_q;
  assign HOST_ADDR = host_addr_q;
  assign HOST_WINV = winv_q;
  assign IRQ_HOST = irq_host_q;
  assign IRQ_LOCAL = irq_local_q;

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  a_mode0_write: assert property (
    wr0 |=> mode_q[0] == ($past(REG_WDATA) & MODE_MASK))
    else $error("mode 0 write not stored");
  a_mode1_read: assert property (
    REG_RD && hit(REG_ADDR, OFF_MODE1) && !REG_WR |=>
      REG_ACK && REG_RDATA == mode_q[1] && REG_RDATA[31:18] == '0)
    else $error("mode 1 readback wrong");
  a_addr_fixed: assert property (
    acc_done && noinc && state_q == ST_XFER |=> $stable(LB_ADDR))
    else $error("fifo address moved");
  a_addr_word_step: assert property (
    acc_done && demand && !noinc |=>
      LB_ADDR == 32'($past(LB_ADDR) + STEP_WORD))
    else $error("demand access not word sized");
  a_demand_hold: assert property (
    state_q == ST_XFER && !lb_rd_q && demand && !req_lvl_q |=> !LB_RD)
    else $error("read issued without request");
  a_ready_wait: assert property (
    lb_rd_q && ready_en && !LB_READY |=> LB_RD && $stable(LB_ADDR))
    else $error("access dropped before ready");
  a_no_burst_gap: assert property (
    acc_done && !burst_en |=> !LB_RD)
    else $error("no idle cycle without burst");
  a_done_irq: assert property (
    done_now && am[F_DONE_IE] |=> IRQ_HOST != IRQ_LOCAL ##1 !IRQ_HOST)
    else $error("done interrupt missing");
  a_irq_quiet: assert property (
    done_now && !am[F_DONE_IE] |=> !IRQ_HOST && !IRQ_LOCAL)
    else $error("interrupt without enable");
  a_chain_fetch: assert property (
    start_any && sel_chain |=> DESC_RD && DESC_ADDR == $past(CH_DESC_PTR))
    else $error("descriptor fetch not started");

  c_chain_done: cover property (desc_end ##[1:200] done_now);
  c_demand_burst: cover property (acc_done && demand && lb_rd_d);
  c_packed_push: cover property (push && pack && lane_q == LANE_LAST);
  c_fifo_stall: cover property (state_q == ST_XFER && !f_in_ready);
endmodule : fdms_top

// ===== verification/fdms_lfifo_model.sv
// local fifo side partner: answers local reads, paces the demand request
// assumes the block's local bus on the same clock, reads only
`timescale 1ns/1ps
module fdms_lfifo_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bench control
  input wire logic slow,
  input wire logic want,
  // local bus
  input wire logic lb_rd,
  output logic lb_ready,
  output logic lb_bterm_n,
  output logic [31:0] lb_data,
  output logic dma_request_line_n
);
  logic [7:0] cnt_q;
  // fifo logic never drives burst-terminate, pulled up
  assign lb_bterm_n = 1'b1;
  assign dma_request_line_n = !want;
  // released bus shows the inverse so stale data never passes
  assign lb_data = lb_rd ? {24'h0, cnt_q} : ~{24'h0, cnt_q};
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lb_ready <= 1'b0;
      cnt_q <= 8'h30;
    end else begin
      // slow mode inserts a wait before every access completes
      lb_ready <= lb_rd && !(slow && lb_ready);
      if (lb_rd && lb_ready) cnt_q <= cnt_q + 8'h01;
    end
  end
endmodule : fdms_lfifo_model

// ===== verification/test_fdms_top.sv
// self-checking bench for the dma channel mode block
// assumes the local fifo partner model and one 10 MHz clock
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_fail++; \
  $display("unexpected t=%0t got %h exp %h", $time, (a), (e)); end end
module test_fdms_top;
  import fdms_pkg::*;
  localparam fdms_word_t M0 = 32'h0002_0d07;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic slow = 1'b0;
  logic want = 1'b1;
  logic host_ready = 1'b1;
  logic desc_ack = 1'b0;
  logic [1:0] ch_start = 2'h0;
  logic [15:0] ch_bytes = 16'h0;
  fdms_addr_t reg_addr = 8'h00;
  fdms_word_t reg_wdata = 32'h0;
  fdms_word_t ch_local = 32'h0;
  fdms_word_t ch_host = 32'h0;
  fdms_word_t ch_desc = 32'h0;
  fdms_word_t desc_data = 32'h0;
  fdms_word_t reg_rdata, desc_addr, lb_addr, lb_data, host_addr;
  fdms_word_t a_exp, a_step;
  logic [31:0] host_data;
  logic [1:0] ch_busy;
  logic reg_ack, desc_rd, lb_rd, lb_last, lb_ready, lb_bterm_n;
  logic dma_request_line_n, host_valid, host_winv, irq_host, irq_local;
  logic prev_rd = 1'b0;
  logic winv_seen = 1'b0;
  int n_fail, checks_done, cycles, n_acc, acc0, n_last, rd_falls;
  int n_irq_h, n_irq_l;
  fdms_word_t got[$];
  fdms_word_t desc_mem [4];

  fdms_top uut (
    .REF_CLK(clk), .RST(rst), .REG_ADDR(reg_addr), .REG_WR(reg_wr),
    .REG_RD(reg_rd), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
    .REG_ACK(reg_ack), .CH_START(ch_start), .CH_LOCAL_ADDR(ch_local),
    .CH_HOST_ADDR(ch_host), .CH_BYTES(ch_bytes), .CH_DESC_PTR(ch_desc),
    .CH_BUSY(ch_busy), .DESC_RD(desc_rd), .DESC_ADDR(desc_addr),
    .DESC_ACK(desc_ack), .DESC_DATA(desc_data), .LB_ADDR(lb_addr),
    .LB_RD(lb_rd), .LB_LAST(lb_last), .LB_READY(lb_ready),
    .LB_BTERM_N(lb_bterm_n), .LB_DATA(lb_data),
    .DMA_REQUEST_LINE_N(dma_request_line_n), .HOST_ADDR(host_addr),
    .HOST_VALID(host_valid), .HOST_DATA(host_data),
    .HOST_READY(host_ready), .HOST_WINV(host_winv),
    .IRQ_HOST(irq_host), .IRQ_LOCAL(irq_local)
  );
  fdms_lfifo_model partner (
    .clk(clk), .rst(rst), .slow(slow), .want(want), .lb_rd(lb_rd),
    .lb_ready(lb_ready), .lb_bterm_n(lb_bterm_n), .lb_data(lb_data),
    .dma_request_line_n(dma_request_line_n)
  );

  always #50 clk = ~clk;

  task automatic close_out;
    if (n_fail == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : close_out

  // monitor and descriptor memory; samples pre-edge values
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      close_out();
    end
    // ack every other cycle so each word meets a settled address
    desc_ack <= desc_rd && !desc_ack;
    desc_data <= desc_rd ? desc_mem[desc_addr[3:2]] : ~desc_data;
    if (host_valid && host_ready) got.push_back(host_data);
    if (host_valid) winv_seen |= host_winv;
    if (irq_host) n_irq_h++;
    if (irq_local) n_irq_l++;
    if (prev_rd && !lb_rd) rd_falls++;
    prev_rd = lb_rd;
    if (lb_rd && lb_ready) begin
      `CHK(lb_addr, a_exp)
      a_exp += a_step;
      n_acc++;
      if (lb_last) n_last++;
    end
  end

  task automatic reg_wr_t(input fdms_addr_t a, input fdms_word_t d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : reg_wr_t

  task automatic reg_rd_t(input fdms_addr_t a, input fdms_word_t e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_ack, 1'b1)
    `CHK(reg_rdata, e)
  endtask : reg_rd_t

  function automatic logic [7:0] pb(input int j);
    return 8'h30 + j[7:0];
  endfunction : pb

  task automatic xfer(input int ch, input logic [15:0] nb,
                      input fdms_word_t st);
    int k, n;
    got.delete();
    n_last = 0;
    rd_falls = 0;
    n_irq_h = 0;
    n_irq_l = 0;
    winv_seen = 1'b0;
    a_exp = 32'h40;
    a_step = st;
    acc0 = n_acc;
    @(posedge clk);
    ch_local <= 32'h0000_0040;
    ch_host <= 32'h0000_9000;
    ch_bytes <= nb;
    ch_start <= 2'h1 << ch;
    @(posedge clk);
    ch_start <= 2'h0;
    #1;
    `CHK(ch_busy, 2'h1 << ch)
    // stalls are lifted after 60 cycles, having checked no local access ran (request stall) or no word reached the host (host stall)
    for (k = 0; k < 3000 && ch_busy !== 2'h0; k++) begin
      @(posedge clk);
      if (k == 60 && !want) begin
        `CHK(n_acc - acc0, 0)
        want <= 1'b1;
      end
      if (k == 60 && !host_ready) begin
        `CHK(got.size(), 0)
        n = n_acc - acc0;
        `CHK(n > 8 && n <= FIFO_DEPTH + 1, 1'b1)
        host_ready <= 1'b1;
      end
    end
    `CHK(ch_busy, 2'h0)
    // a stalled host leaves words queued after the engine goes idle
    for (k = 0; k < 40 && host_valid; k++) @(posedge clk);
    repeat (3) @(posedge clk);
  endtask : xfer

  task automatic check_words(input int n, input bit pack);
    fdms_word_t e;
    int b;
    `CHK(got.size(), n)
    for (int k = 0; k < n && k < got.size(); k++) begin
      b = acc0 + 4 * k;
      e = pack ? {pb(b + 3), pb(b + 2), pb(b + 1), pb(b)} :
                 {24'h0, pb(acc0 + k)};
      `CHK(got[k], e)
    end
  endtask : check_words

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    reg_rd_t(OFF_MODE0, MODE_RST);
    reg_rd_t(OFF_MODE1, MODE_RST);
    reg_wr_t(OFF_MODE0, 32'hffff_ffff);
    reg_wr_t(8'h84, 32'h0000_1234);
    reg_rd_t(OFF_MODE0, MODE_MASK);
    reg_rd_t(8'h84, 32'h0000_0000);
    reg_wr_t(OFF_MODE1, 32'h0000_0404);
    reg_rd_t(OFF_MODE1, 32'h0000_0404);
    reg_wr_t(OFF_MODE0, M0);
    slow <= 1'b1;
    xfer(0, 16'd14, 32'h0);
    check_words(4, 1'b0);
    `CHK(n_last, 1)
    `CHK(n_irq_h, 1)
    `CHK(n_irq_l, 0)
    `CHK(host_addr, 32'h0000_9000)
    `CHK(winv_seen, 1'b0)
    slow <= 1'b0;
    xfer(0, 16'd16, 32'h0);
    check_words(4, 1'b0);
    `CHK(rd_falls, 1)
    xfer(1, 16'd8, 32'h1);
    check_words(2, 1'b1);
    `CHK(rd_falls, 8)
    `CHK(n_irq_l, 1)
    `CHK(n_irq_h, 0)
    reg_wr_t(OFF_MODE0, M0 | 32'h0000_1000);
    want <= 1'b0;
    repeat (6) @(posedge clk);
    xfer(0, 16'd8, 32'h0);
    check_words(2, 1'b0);
    desc_mem = '{32'h40, 32'h0001_2300, 32'h8, 32'h0};
    ch_desc <= 32'h0000_0100;
    reg_wr_t(OFF_MODE0, M0 | 32'h0000_2200);
    xfer(0, 16'd0, 32'h0);
    check_words(2, 1'b0);
    `CHK(host_addr, 32'h0001_2300)
    `CHK(winv_seen, 1'b1)
    reg_wr_t(OFF_MODE0, M0);
    host_ready <= 1'b0;
    xfer(0, 16'd80, 32'h0);
    check_words(20, 1'b0);
    close_out();
  end
endmodule : test_fdms_top
